// [common/stx_consts.svh]
// Offsets, field positions, reset values and timing counts of the serial transmit block
`ifndef STX_CONSTS_SVH
`define STX_CONSTS_SVH

// Register word addresses
`define STX_ADDR_STA        4'h0
`define STX_ADDR_TXDATA     4'h1
`define STX_ADDR_RXDATA     4'h2
`define STX_ADDR_IRQ_STATUS 4'h3
`define STX_ADDR_IRQ_MASK   4'h4
`define STX_ADDR_BAUD       4'h5

// Status/control field positions
`define STX_BIT_TXISEL1     15
`define STX_BIT_TXINV       14
`define STX_BIT_TXISEL0     13
`define STX_BIT_UNIMPL      12
`define STX_BIT_BREAK       11
`define STX_BIT_TXEN        10
`define STX_BIT_TXBF        9
`define STX_BIT_TX_SHIFT_EMPTY        8
`define STX_BIT_RXISEL1     7
`define STX_BIT_RXISEL0     6
`define STX_BIT_INFRARED_ENCODE_ON        0

// Reset values
`define STX_STA_RESET       16'h0000
`define STX_BAUD_RESET      16'h0363

// Interrupt status bits
`define STX_IRQ_TX          0
`define STX_IRQ_RX          1

// Buffer sizes and fill levels
`define STX_TX_DEPTH        4
`define STX_RX_DEPTH        4
`define STX_RX_LVL_FULL     3'h4
`define STX_RX_LVL_3Q       3'h3

// Bit times sent between the start bit and the stop bit
`define STX_DATA_BITS       4'h8
`define STX_BREAK_BITS      4'hC

`endif

// [common/stx_pkg.sv]
// Types shared by the serial transmit block
package stx_pkg;

    // Transmit interrupt modes
    typedef enum logic [1:0] {
        STX_TXI_ANY   = 2'h0,
        STX_TXI_DONE  = 2'h1,
        STX_TXI_EMPTY = 2'h2,
        STX_TXI_RSVD  = 2'h3
    } stx_txi_t;

    // Shifter states
    typedef enum logic [1:0] {
        STX_IDLE  = 2'h0,
        STX_START = 2'h1,
        STX_DATA  = 2'h2,
        STX_STOP  = 2'h3
    } stx_state_t;

endpackage : stx_pkg

// [verilog/stx_baud.sv]
// Bit-time tick generator
`timescale 1ns/1ns
`default_nettype none
module stx_baud (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        run,
    input  wire logic [15:0] divisor,
    output logic             tick
);
    logic [15:0] count;  // Cycles left in bit time

    // Count down, pulse at zero; reload while stopped so the start bit is full length
    always_ff @(posedge CLK) begin
        if (!RSTN || !run) begin
            count <= divisor;
            tick  <= 1'b0;
        end else if (count == 16'h0000) begin
            count <= divisor;
            tick  <= 1'b1;
        end else begin
            count <= count - 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule : stx_baud
`default_nettype wire

// [verilog/stx_rxq.sv]
// Receive buffer of four characters with fill-level output
`timescale 1ns/1ns
`default_nettype none
`include "stx_consts.svh"
module stx_rxq (
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic       push,
    input  wire logic [7:0] push_data,
    input  wire logic       pop,
    output logic [7:0]      head,
    output logic [2:0]      level
);
    logic [7:0] mem [0:3];  // Character storage
    logic [1:0] wptr;       // Write pointer
    logic [1:0] rptr;       // Read pointer
    logic       do_push;    // Accepted push
    logic       do_pop;     // Accepted pop

    assign do_push = push && (level != `STX_RX_LVL_FULL);
    assign do_pop  = pop && (level != 3'h0);
    assign head    = mem[rptr];

    // Storage write
    always_ff @(posedge CLK) begin
        if (do_push) begin
            mem[wptr] <= push_data;
        end
    end

    // Pointers and level
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            wptr  <= 2'h0;
            rptr  <= 2'h0;
            level <= 3'h0;
        end else begin
            if (do_push) begin
                wptr <= wptr + 2'h1;
            end
            if (do_pop) begin
                rptr <= rptr + 2'h1;
            end
            level <= level + {2'h0, do_push} - {2'h0, do_pop};
        end
    end
endmodule : stx_rxq
`default_nettype wire

// [verilog/stx_top.sv]
// Serial port transmit control, status and interrupt-mode logic
`timescale 1ns/1ns
`default_nettype none
`include "stx_consts.svh"
module stx_top
    import stx_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic        SERIAL_IN_PIN,
    output logic             SERIAL_OUT_PIN,
    output logic             SERIAL_OUT_OE,
    output logic             IRQ
);
    import stx_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////
    logic [1:0]  tx_irq_mode;         // Transmit interrupt mode
    logic        tx_polarity_invert;  // Output inversion
    logic        infrared_encode_on;  // Pulse encoding on
    logic        send_break;          // Break request
    logic        tx_enable;           // Transmit enable
    logic [1:0]  rx_irq_mode;         // Receive interrupt mode
    logic [15:0] baud_div;            // Bit time divisor
    logic [1:0]  irq_status;          // Sticky events
    logic [1:0]  irq_mask;            // Event enables
    logic [7:0]  txb [0:3];           // Transmit buffer
    logic [1:0]  tx_wp;               // Buffer write pointer
    logic [1:0]  tx_rp;               // Buffer read pointer
    logic [2:0]  tx_cnt;              // Buffer fill
    stx_state_t  state;               // Shifter state
    logic [11:0] shreg;               // Shift data
    logic [3:0]  bitn;                // Bits left
    logic        is_break;            // Frame is a break
    logic        line;                // Unencoded line level
    logic        tick;                // Bit time pulse
    logic        tx_push;             // Accepted write
    logic        tx_load;             // Shifter load
    logic        tx_done;             // Last frame finished
    logic        tx_buffer_full;      // No free slot
    logic        tx_shift_empty;      // All idle
    logic        rx_s1;               // Input sync stage 1
    logic        rx_s2;               // Input sync stage 2
    logic        rx_push;             // Received character
    logic [7:0]  rx_char;             // Received value
    logic [7:0]  rx_head;             // Oldest received
    logic [2:0]  rx_level;            // Receive fill
    logic [2:0]  rx_level_d;          // Previous fill
    logic        rx_pop;              // Data read
    logic        tx_ev;               // Transmit event
    logic        rx_ev;               // Receive event
    logic        next_out;            // Next pin level

    // Effective transmit mode, reserved folds to 00
    function automatic stx_txi_t eff_mode(input logic [1:0] m);
        eff_mode = (m == 2'h3) ? STX_TXI_ANY : stx_txi_t'(m);
    endfunction : eff_mode

    ////////////////////////////////////////////////////////////////////////
    // Sub-blocks
    ////////////////////////////////////////////////////////////////////////
    stx_baud u_baud (
        .CLK     (CLK),
        .RSTN    (RSTN),
        .run     (state != STX_IDLE),
        .divisor (baud_div),
        .tick    (tick)
    );

    stx_rxq u_rxq (
        .CLK       (CLK),
        .RSTN      (RSTN),
        .push      (rx_push),
        .push_data (rx_char),
        .pop       (rx_pop),
        .head      (rx_head),
        .level     (rx_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    ////////////////////////////////////////////////////////////////////////
    assign tx_push = WR && (ADDR == `STX_ADDR_TXDATA) && tx_enable && !tx_buffer_full;
    assign rx_pop  = RD && (ADDR == `STX_ADDR_RXDATA);

    // Control fields
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            tx_irq_mode        <= 2'h0;
            tx_polarity_invert <= 1'b0;
            infrared_encode_on <= 1'b0;
            tx_enable          <= 1'b0;
            rx_irq_mode        <= 2'h0;
            baud_div           <= `STX_BAUD_RESET;
            irq_mask           <= 2'h0;
        end else if (WR) begin
            case (ADDR)
                `STX_ADDR_STA: begin
                    tx_irq_mode        <= {WDATA[`STX_BIT_TXISEL1], WDATA[`STX_BIT_TXISEL0]};
                    tx_polarity_invert <= WDATA[`STX_BIT_TXINV];
                    tx_enable          <= WDATA[`STX_BIT_TXEN];
                    rx_irq_mode        <= WDATA[`STX_BIT_RXISEL1:`STX_BIT_RXISEL0];
                    infrared_encode_on <= WDATA[`STX_BIT_INFRARED_ENCODE_ON];
                end
                `STX_ADDR_BAUD:     baud_div <= WDATA;
                `STX_ADDR_IRQ_MASK: irq_mask <= WDATA[1:0];
                default: ;
            endcase
        end
    end

    // Break bit: set by software, cleared by hardware after break frame
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            send_break <= 1'b0;
        end else if (!tx_enable) begin
            send_break <= 1'b0;
        end else if (state == STX_STOP && tick && is_break) begin
            send_break <= 1'b0;
        end else if (WR && ADDR == `STX_ADDR_STA && WDATA[`STX_BIT_BREAK]) begin
            send_break <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit buffer
    ////////////////////////////////////////////////////////////////////////
    assign tx_buffer_full = (tx_cnt == 3'h4);
    assign tx_load = tx_enable && state == STX_IDLE && (tx_cnt != 3'h0 || send_break);
    assign tx_shift_empty = (state == STX_IDLE) && (tx_cnt == 3'h0);

    // Storage write
    always_ff @(posedge CLK) begin
        if (tx_push) begin
            txb[tx_wp] <= WDATA[7:0];
        end
    end

    // Pointers, flushed when disabled
    always_ff @(posedge CLK) begin
        if (!RSTN || !tx_enable) begin
            tx_wp  <= 2'h0;
            tx_rp  <= 2'h0;
            tx_cnt <= 3'h0;
        end else begin
            if (tx_push) begin
                tx_wp <= tx_wp + 2'h1;
            end
            if (tx_load && !send_break) begin
                tx_rp <= tx_rp + 2'h1;
            end
            tx_cnt <= tx_cnt + {2'h0, tx_push} - {2'h0, tx_load && !send_break};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shifter
    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer; break frame sends twelve zero bits
    always_ff @(posedge CLK) begin
        if (!RSTN || !tx_enable) begin
            state    <= STX_IDLE;
            shreg    <= 12'h000;
            bitn     <= 4'h0;
            is_break <= 1'b0;
            line     <= 1'b1;
        end else begin
            case (state)
                STX_IDLE: begin
                    line <= 1'b1;
                    if (tx_load) begin
                        is_break <= send_break;
                        shreg    <= send_break ? 12'h000 : {4'h0, txb[tx_rp]};
                        bitn     <= send_break ? `STX_BREAK_BITS : `STX_DATA_BITS;
                        state    <= STX_START;
                        line     <= 1'b0;
                    end
                end
                STX_START: begin
                    if (tick) begin
                        line  <= shreg[0];
                        shreg <= {1'b0, shreg[11:1]};
                        bitn  <= bitn - 4'h1;
                        state <= STX_DATA;
                    end
                end
                STX_DATA: begin
                    if (tick) begin
                        if (bitn == 4'h0) begin
                            line  <= 1'b1;
                            state <= STX_STOP;
                        end else begin
                            line  <= shreg[0];
                            shreg <= {1'b0, shreg[11:1]};
                            bitn  <= bitn - 4'h1;
                        end
                    end
                end
                STX_STOP: begin
                    if (tick) begin
                        state <= STX_IDLE;
                    end
                end
                default: state <= STX_IDLE;
            endcase
        end
    end

    assign tx_done = (state == STX_STOP) && tick && (tx_cnt == 3'h0) && !send_break;

    // Transmit event selection
    always_comb begin
        case (eff_mode(tx_irq_mode))
            STX_TXI_EMPTY: tx_ev = tx_load && !send_break && tx_cnt == 3'h1 && !tx_push;
            STX_TXI_DONE:  tx_ev = tx_done;
            default:       tx_ev = tx_load && !send_break;
        endcase
    end

    // Output level: idle polarity depends on encoding and inversion
    always_comb begin
        if (infrared_encode_on) begin
            next_out = (!line && tick) ^ tx_polarity_invert;
        end else begin
            next_out = line ^ tx_polarity_invert;
        end
    end

    // Pin drive, released to port when disabled
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            SERIAL_OUT_PIN <= 1'b1;
            SERIAL_OUT_OE  <= 1'b0;
        end else begin
            SERIAL_OUT_PIN <= next_out;
            SERIAL_OUT_OE  <= tx_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive path (simplified: caller-facing level events)
    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser and previous receive fill; the loop-back push is tied to zero
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rx_s1      <= 1'b1;
            rx_s2      <= 1'b1;
            rx_level_d <= 3'h0;
        end else begin
            rx_s1      <= SERIAL_IN_PIN;
            rx_s2      <= rx_s1;
            rx_level_d <= rx_level;
        end
    end

    assign rx_push = tx_done && !rx_s2 && 1'b0;
    assign rx_char = rx_head;

    // Receive event selection on a transfer into the buffer
    always_comb begin
        rx_ev = 1'b0;
        if (rx_level > rx_level_d) begin
            case (rx_irq_mode)
                2'h3:    rx_ev = (rx_level == `STX_RX_LVL_FULL);
                2'h2:    rx_ev = (rx_level == `STX_RX_LVL_3Q);
                default: rx_ev = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts and read-back
    ////////////////////////////////////////////////////////////////////////
    // Sticky status, set wins over write-one-to-clear
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= (irq_status & ~((WR && ADDR == `STX_ADDR_IRQ_STATUS) ?
                          WDATA[1:0] : 2'h0)) | {rx_ev, tx_ev};
        end
    end

    // Level interrupt output
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_status & irq_mask);
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            case (ADDR)
                `STX_ADDR_STA: RDATA <= {tx_irq_mode[1], tx_polarity_invert, tx_irq_mode[0],
                                         1'b0, send_break, tx_enable,
                                         tx_buffer_full, tx_shift_empty,
                                         rx_irq_mode, 5'h00, infrared_encode_on};
                `STX_ADDR_RXDATA:     RDATA <= {8'h00, rx_head};
                `STX_ADDR_IRQ_STATUS: RDATA <= {14'h0000, irq_status};
                `STX_ADDR_IRQ_MASK:   RDATA <= {14'h0000, irq_mask};
                `STX_ADDR_BAUD:       RDATA <= baud_div;
                default:              RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////
    property p_full;
        @(posedge CLK) disable iff (!RSTN) tx_buffer_full |-> tx_cnt == 3'h4;
    endproperty
    a_full: assert property (p_full) else $error("full flag wrong");

    property p_empty;
        @(posedge CLK) disable iff (!RSTN) tx_shift_empty |-> !is_break || state == STX_IDLE;
    endproperty
    a_empty: assert property (p_empty) else $error("empty flag wrong");

    property p_oe;
        @(posedge CLK) disable iff (!RSTN) !tx_enable |=> !SERIAL_OUT_OE && state == STX_IDLE;
    endproperty
    a_oe: assert property (p_oe) else $error("disable not honoured");

    property p_en;
        @(posedge CLK) disable iff (!RSTN) tx_enable |=> SERIAL_OUT_OE;
    endproperty
    a_en: assert property (p_en) else $error("pin not driven");

    property p_idle;
        @(posedge CLK) disable iff (!RSTN)
            (state == STX_IDLE && !infrared_encode_on && $stable(tx_polarity_invert))
            |=> SERIAL_OUT_PIN == !$past(tx_polarity_invert);
    endproperty
    a_idle: assert property (p_idle) else $error("idle level wrong");

    property p_rsvd;
        @(posedge CLK) disable iff (!RSTN)
            (tx_irq_mode == 2'h3 && tx_load && !send_break) |=> irq_status[`STX_IRQ_TX];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mode wrong");

    property p_rx4;
        @(posedge CLK) disable iff (!RSTN) (rx_ev && rx_irq_mode == 2'h3) |-> rx_level == 3'h4;
    endproperty
    a_rx4: assert property (p_rx4) else $error("rx full event wrong");

    property p_irq;
        @(posedge CLK) disable iff (!RSTN) |(irq_status & irq_mask) |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    c_break: cover property (@(posedge CLK) disable iff (!RSTN) is_break && state == STX_STOP);
    c_done:  cover property (@(posedge CLK) disable iff (!RSTN) tx_done);
    c_full:  cover property (@(posedge CLK) disable iff (!RSTN) tx_buffer_full);

endmodule : stx_top
`default_nettype wire

// [testbench/stx_remote.sv]
// Remote serial receiver model that decodes frames and breaks
`timescale 1ns/1ns
`default_nettype none
module stx_remote #(
    parameter int BIT = 16            // Cycles per bit time
) (
    input  wire logic       clk,
    input  wire logic       on,
    input  wire logic       line,
    output logic            rx_pin,
    output logic            got,
    output logic [8:0]      note
);
    logic [13:0] s;                   // Mid-bit samples of one frame
    // Own transmit line parked at the mark level
    assign rx_pin = 1'b1;
    initial got = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Abandon a frame when the bench switches the model off
    always @(negedge on) disable dec;
    // Decode start, eight data bits LSB first, then stop or break tail
    always begin : dec
        @(posedge clk);
        got <= 1'b0;
        if (on && !line) begin
            s = '1;
            repeat (BIT / 2) @(posedge clk);
            for (int i = 0; i < 14; i++) begin
                s[i] = line;
                if ((i == 9 && line) || i == 13) break;
                repeat (BIT) @(posedge clk);
            end
            // Break: start and twelve lows, then a high stop
            note <= s[9] ? {1'b0, s[8:1]} : {s[13] && s[12:0] == 13'h0, s[8:1]};
            got <= 1'b1;
        end
    end
endmodule : stx_remote
`default_nettype wire

// [testbench/uart_tx_status_irq_modes_tb_top.sv]
// Self-checking bench for the serial transmit control block
`timescale 1ns/1ns
`default_nettype none
`include "stx_consts.svh"
module uart_tx_status_irq_modes_tb_top;
    logic        clk, rstn, wr, rd, on, rd_seen;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, v;
    logic        out_pin, out_oe, irq, in_pin, got;
    logic [8:0]  note;
    logic [31:0] rq[$];               // Read notes: mask, expected
    logic [8:0]  sq[$];               // Serial notes: break flag, byte
    logic [31:0] n;
    int          num_errors, checks;
    wire         line = out_oe ? out_pin : 1'b1; // Pull-up when released
    stx_top dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SERIAL_IN_PIN(in_pin),
        .SERIAL_OUT_PIN(out_pin), .SERIAL_OUT_OE(out_oe), .IRQ(irq));
    stx_remote #(.BIT(16)) far (.clk(clk), .on(on), .line(line),
        .rx_pin(in_pin), .got(got), .note(note));
    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One-cycle register write
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read, noting the masked expectation; a zero mask only peeks into v
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] m,
                          input logic [15:0] e);
        rq.push_back({m, e});
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask : rd_reg
    // Queue a character and note it for the far side
    task automatic send(input logic [7:0] d);
        wr_reg(`STX_ADDR_TXDATA, {8'h00, d});
        sq.push_back({1'b0, d});
    endtask : send
    // Poll the shift-empty flag under a bound
    task automatic wait_idle();
        v = 16'h0000;
        for (int k = 0; k < 1500 && v[8] !== 1'b1; k++) rd_reg(`STX_ADDR_STA, 0, 0);
        chk(v & 16'h0300, 16'h0100, "idle");
    endtask : wait_idle
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        close_out();
    end
    // Output watcher: takes the oldest note whenever a result appears
    always @(posedge clk) begin
        if (rd_seen) begin
            n = rq.pop_front();
            if (n[31:16] != 16'h0) chk(rdata & n[31:16], n[15:0], "rdata");
        end
        rd_seen <= rd;
        if (got) chk({7'h0, note}, sq.size() ? {7'h0, sq.pop_front()} : 16'hFFFF, "serial");
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rstn, wr, rd, on, rd_seen, addr, wdata} = '0;
        num_errors = 0;
        checks = 0;
        void'($urandom(32'h0CA3));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        // Reset state; read-only and unused bits ignore writes
        chk({15'h0, out_oe}, 16'h0000, "oe");
        rd_reg(`STX_ADDR_STA, 16'hFFFF, 16'h0100);
        wr_reg(`STX_ADDR_STA, 16'h1300);
        rd_reg(`STX_ADDR_STA, 16'hFFFF, 16'h0100);
        rd_reg(4'hF, 16'hFFFF, 16'h0000);
        $display("test reset done");
        // Idle level for each inversion and encoding choice
        for (int i = 0; i < 4; i++) begin
            wr_reg(`STX_ADDR_STA, {1'b0, i[0], 4'b0001, 9'h0, i[1]});
            repeat (3) @(posedge clk);
            chk({out_oe, out_pin}, {1'b1, i[0] ~^ i[1]}, "idle");
        end
        wr_reg(`STX_ADDR_BAUD, 16'h000F);
        wr_reg(`STX_ADDR_IRQ_MASK, 16'h0001);
        wr_reg(`STX_ADDR_STA, 16'h0400);
        repeat (40) @(posedge clk);
        on <= 1'b1;
        $display("test idle done");
        // Each transmit interrupt mode, including the reserved one
        for (int m = 0; m < 4; m++) begin
            wr_reg(`STX_ADDR_STA, {m[1], 1'b0, m[0], 13'h0400});
            for (int j = 0; j < 3; j++) send($urandom);
            repeat (40) @(posedge clk);
            wr_reg(`STX_ADDR_IRQ_STATUS, 16'h0001);
            repeat (150) @(posedge clk);
            chk({15'h0, irq}, {15'h0, m == 0 || m == 3}, "irq");
            rd_reg(`STX_ADDR_IRQ_STATUS, 16'h0001, {15'h0, m == 0 || m == 3});
            wait_idle();
            rd_reg(`STX_ADDR_IRQ_STATUS, 16'h0001, 16'h0001);
            $display("test tx mode %0d done", m);
        end
        // Masking and clearing the interrupt
        wr_reg(`STX_ADDR_IRQ_MASK, 16'h0000);
        repeat (2) @(posedge clk);
        chk({15'h0, irq}, 16'h0000, "irq masked");
        wr_reg(`STX_ADDR_IRQ_MASK, 16'h0001);
        repeat (2) @(posedge clk);
        chk({15'h0, irq}, 16'h0001, "irq unmasked");
        wr_reg(`STX_ADDR_IRQ_STATUS, 16'h0001);
        repeat (2) @(posedge clk);
        chk({15'h0, irq}, 16'h0000, "irq cleared");
        // Fill the buffer until it refuses
        for (int j = 0; j < 5; j++) send($urandom);
        rd_reg(`STX_ADDR_STA, 16'h0300, 16'h0200);
        wr_reg(`STX_ADDR_TXDATA, 16'h00FF);
        wait_idle();
        $display("test fill done");
        // Break frame, bit cleared by hardware
        wr_reg(`STX_ADDR_STA, 16'h0C00);
        wr_reg(`STX_ADDR_TXDATA, 16'h0000);
        sq.push_back(9'h100);
        sq.push_back(9'h000);
        wait_idle();
        rd_reg(`STX_ADDR_STA, 16'h0800, 16'h0000);
        $display("test break done");
        // Abort in mid-frame flushes the buffer and releases the pin
        for (int j = 0; j < 3; j++) wr_reg(`STX_ADDR_TXDATA, 16'h0033);
        repeat (50) @(posedge clk);
        on <= 1'b0;
        wr_reg(`STX_ADDR_STA, 16'h0000);
        repeat (2) @(posedge clk);
        chk({15'h0, out_oe}, 16'h0000, "oe");
        rd_reg(`STX_ADDR_STA, 16'h0700, 16'h0100);
        wr_reg(`STX_ADDR_STA, 16'h0400);
        repeat (20) @(posedge clk);
        on <= 1'b1;
        send($urandom);
        wait_idle();
        repeat (40) @(posedge clk);
        chk(sq.size(), 16'h0000, "pending");
        $display("test abort done");
        close_out();
    end
endmodule : uart_tx_status_irq_modes_tb_top
`default_nettype wire
